// >>> rtl/ldw_fifo.sv
// Byte FIFO with registered read data, valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ldw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [AW:0] count_r, count_nxt;
   logic [WIDTH-1:0] out_data_r, out_data_nxt;
   logic out_valid_r, out_valid_nxt, in_ready_r, in_ready_nxt;
   logic push, pop;

   // ==========================================================
   // Pointer and level update
   always_comb begin
      push = in_valid && in_ready_r;
      pop = out_ready && out_valid_r;
      wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
      out_valid_nxt = (count_nxt != '0);
      in_ready_nxt = (count_nxt != DEPTH_C);
      // Bypass when the word being written is the next head
      if (push && (wr_ptr_r == rd_ptr_nxt)) begin
         out_data_nxt = in_data;
      end else begin
         out_data_nxt = mem[rd_ptr_nxt];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         out_data_r <= '0;
         out_valid_r <= 1'b0;
         in_ready_r <= 1'b0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         out_data_r <= out_data_nxt;
         out_valid_r <= out_valid_nxt;
         in_ready_r <= in_ready_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   assign in_ready = in_ready_r;
   assign out_data = out_data_r;
   assign out_valid = out_valid_r;
endmodule
`default_nettype wire

// >>> rtl/ldw_pkg.sv
// Shared constants and types for the LPC DMA write byte sequencer
package ldw_pkg;
   // ==========================================================
   // Field codes on the nibble bus
   localparam logic [3:0] LAD_START = 4'h0;
   localparam logic [2:0] CYC_DMA_WR = 3'h5;
   localparam logic [1:0] SIZE_8BIT = 2'h0;
   localparam logic [3:0] LAD_TAR = 4'hF;
   localparam logic [3:0] SYNC_WAIT = 4'h5;
   localparam logic [3:0] SYNC_MORE = 4'h9;
   localparam logic [3:0] SYNC_DONE = 4'h0;
   // ==========================================================
   // Field positions
   localparam int CHAN_TC_BIT = 3;
   localparam int REQ_BITS = 6;
   // ==========================================================
   // Timing counts in clocks
   localparam logic [1:0] WAIT_LAST = 2'h3;
   localparam logic [3:0] QUIET_CLKS = 4'h8;
   localparam logic [2:0] REQ_LAST = 3'h5;
   // ==========================================================
   // Data buffer shape
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   // ==========================================================
   // Cycle sequencer states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_CYC,
      ST_CHAN,
      ST_SIZE,
      ST_TAR1,
      ST_TAR2,
      ST_WAIT,
      ST_SYNC,
      ST_DLO,
      ST_DHI,
      ST_TARD
   } ldw_state_t;
endpackage

// >>> rtl/ldw_seq.sv
// LPC DMA write byte sequencer, peripheral side
`timescale 1ns/1ns
`default_nettype none
module ldw_seq (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // LPC bus
   input wire logic lframe_n,
   input wire logic [3:0] lad_in,
   output logic [3:0] lad_out,
   output logic lad_oe,
   output logic ldrq_n,
   // Channel control
   input wire logic dma_en,
   input wire logic [2:0] dma_chan,
   output logic xfer_done,
   // Byte source
   input wire logic [7:0] wr_data,
   input wire logic wr_valid,
   output logic wr_ready
);
   // ==========================================================
   // Data buffer
   logic [7:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;

   ldw_fifo #(
      .WIDTH(ldw_pkg::FIFO_WIDTH),
      .DEPTH(ldw_pkg::FIFO_DEPTH)
   ) ldw_fifo_i (
      .clk(sys_clk),
      .rst(rst),
      .in_data(wr_data),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // ==========================================================
   // Cycle sequencer
   ldw_pkg::ldw_state_t state_r, state_nxt;
   logic [1:0] wcnt_r, wcnt_nxt;
   logic tc_r, tc_nxt;
   logic [7:0] byte_r, byte_nxt;
   logic [3:0] lad_out_r, lad_out_nxt;
   logic lad_oe_r, lad_oe_nxt;
   logic req_pend_r;
   logic [2:0] req_ch_r;
   logic start_seen;

   always_comb begin
      state_nxt = state_r;
      wcnt_nxt = wcnt_r;
      tc_nxt = tc_r;
      byte_nxt = byte_r;
      start_seen = !lframe_n && (lad_in == ldw_pkg::LAD_START);
      case (state_r)
         ldw_pkg::ST_IDLE: begin
            if (start_seen) begin
               state_nxt = ldw_pkg::ST_CYC;
            end
         end
         ldw_pkg::ST_CYC: begin
            if (!lframe_n) begin
               state_nxt = start_seen ? ldw_pkg::ST_CYC : ldw_pkg::ST_IDLE;
            end else if (lad_in[3:1] == ldw_pkg::CYC_DMA_WR) begin
               state_nxt = ldw_pkg::ST_CHAN;
            end else begin
               state_nxt = ldw_pkg::ST_IDLE;
            end
         end
         ldw_pkg::ST_CHAN: begin
            tc_nxt = lad_in[ldw_pkg::CHAN_TC_BIT];
            if (lad_in[2:0] == req_ch_r && req_pend_r && fifo_valid) begin
               state_nxt = ldw_pkg::ST_SIZE;
            end else begin
               state_nxt = ldw_pkg::ST_IDLE;
            end
         end
         ldw_pkg::ST_SIZE: begin
            if (lad_in[1:0] == ldw_pkg::SIZE_8BIT) begin
               state_nxt = ldw_pkg::ST_TAR1;
            end else begin
               state_nxt = ldw_pkg::ST_IDLE;
            end
         end
         ldw_pkg::ST_TAR1: begin
            state_nxt = ldw_pkg::ST_TAR2;
         end
         ldw_pkg::ST_TAR2: begin
            state_nxt = ldw_pkg::ST_WAIT;
            wcnt_nxt = '0;
            byte_nxt = fifo_data;
         end
         ldw_pkg::ST_WAIT: begin
            wcnt_nxt = wcnt_r + 1'b1;
            if (wcnt_r == ldw_pkg::WAIT_LAST) begin
               state_nxt = ldw_pkg::ST_SYNC;
            end
         end
         ldw_pkg::ST_SYNC: begin
            state_nxt = ldw_pkg::ST_DLO;
         end
         ldw_pkg::ST_DLO: begin
            state_nxt = ldw_pkg::ST_DHI;
         end
         ldw_pkg::ST_DHI: begin
            state_nxt = ldw_pkg::ST_TARD;
         end
         ldw_pkg::ST_TARD: begin
            state_nxt = ldw_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = ldw_pkg::ST_IDLE;
         end
      endcase
      // Host abort or restart during the header phase
      if (!lframe_n && state_r != ldw_pkg::ST_IDLE && state_r != ldw_pkg::ST_CYC &&
          state_r < ldw_pkg::ST_WAIT) begin
         state_nxt = start_seen ? ldw_pkg::ST_CYC : ldw_pkg::ST_IDLE;
      end
      // Pin values for the next clock follow the next state
      lad_oe_nxt = 1'b1;
      case (state_nxt)
         ldw_pkg::ST_WAIT: lad_out_nxt = ldw_pkg::SYNC_WAIT;
         ldw_pkg::ST_SYNC: lad_out_nxt = tc_r ? ldw_pkg::SYNC_DONE : ldw_pkg::SYNC_MORE;
         ldw_pkg::ST_DLO: lad_out_nxt = byte_r[3:0];
         ldw_pkg::ST_DHI: lad_out_nxt = byte_r[7:4];
         ldw_pkg::ST_TARD: lad_out_nxt = ldw_pkg::LAD_TAR;
         default: begin
            lad_out_nxt = ldw_pkg::LAD_TAR;
            lad_oe_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= ldw_pkg::ST_IDLE;
         wcnt_r <= '0;
         tc_r <= 1'b0;
         byte_r <= '0;
         lad_out_r <= ldw_pkg::LAD_TAR;
         lad_oe_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wcnt_r <= wcnt_nxt;
         tc_r <= tc_nxt;
         byte_r <= byte_nxt;
         lad_out_r <= lad_out_nxt;
         lad_oe_r <= lad_oe_nxt;
      end
   end

   assign fifo_pop = (state_r == ldw_pkg::ST_DHI);

   // ==========================================================
   // Serial request and channel progress
   logic req_pend_nxt;
   logic [2:0] req_ch_nxt;
   logic shifting_r, shifting_nxt;
   logic [ldw_pkg::REQ_BITS-1:0] sh_r, sh_nxt;
   logic [2:0] sh_cnt_r, sh_cnt_nxt;
   logic [3:0] quiet_r, quiet_nxt;
   logic ldrq_n_r, ldrq_n_nxt;
   logic done_r, done_nxt;

   always_comb begin
      req_pend_nxt = req_pend_r;
      req_ch_nxt = req_ch_r;
      shifting_nxt = shifting_r;
      sh_nxt = sh_r;
      sh_cnt_nxt = sh_cnt_r;
      quiet_nxt = (quiet_r != '0) ? quiet_r - 1'b1 : quiet_r;
      done_nxt = 1'b0;
      if (shifting_r) begin
         if (sh_cnt_r == ldw_pkg::REQ_LAST) begin
            shifting_nxt = 1'b0;
            req_pend_nxt = 1'b1;
         end else begin
            sh_nxt = {sh_r[ldw_pkg::REQ_BITS-2:0], 1'b1};
            sh_cnt_nxt = sh_cnt_r + 1'b1;
         end
      end else if (!req_pend_r && quiet_r == '0 && dma_en && fifo_valid) begin
         shifting_nxt = 1'b1;
         req_ch_nxt = dma_chan;
         sh_nxt = {1'b0, dma_chan, 1'b1, 1'b1};
         sh_cnt_nxt = '0;
      end
      // Progress stays pending until the sync of the terminal count byte
      if (state_r == ldw_pkg::ST_SYNC && tc_r) begin
         req_pend_nxt = 1'b0;
         quiet_nxt = ldw_pkg::QUIET_CLKS;
         done_nxt = 1'b1;
      end
      ldrq_n_nxt = shifting_nxt ? sh_nxt[ldw_pkg::REQ_BITS-1] : 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req_pend_r <= 1'b0;
         req_ch_r <= '0;
         shifting_r <= 1'b0;
         sh_r <= '1;
         sh_cnt_r <= '0;
         quiet_r <= '0;
         ldrq_n_r <= 1'b1;
         done_r <= 1'b0;
      end else begin
         req_pend_r <= req_pend_nxt;
         req_ch_r <= req_ch_nxt;
         shifting_r <= shifting_nxt;
         sh_r <= sh_nxt;
         sh_cnt_r <= sh_cnt_nxt;
         quiet_r <= quiet_nxt;
         ldrq_n_r <= ldrq_n_nxt;
         done_r <= done_nxt;
      end
   end

   assign lad_out = lad_out_r;
   assign lad_oe = lad_oe_r;
   assign ldrq_n = ldrq_n_r;
   assign xfer_done = done_r;

   // ==========================================================
   // Checks
   sequence s_waits;
      (lad_oe_r && lad_out_r == ldw_pkg::SYNC_WAIT) [*4];
   endsequence

   sequence s_data_out;
      (lad_out_r == byte_r[3:0]) ##1 (lad_out_r == byte_r[7:4]);
   endsequence

   sequence s_tar_release;
      (lad_oe_r && lad_out_r == ldw_pkg::LAD_TAR) ##1 !lad_oe_r;
   endsequence

   a_quiet_gap: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ldw_pkg::ST_SYNC && tc_r) |=> ldrq_n_r [*8])
      else $error("request line not quiet after final sync");

   a_wait_count: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(lad_oe_r) |-> s_waits ##1 (lad_out_r == ldw_pkg::SYNC_MORE || lad_out_r == ldw_pkg::SYNC_DONE))
      else $error("wrong number of wait syncs");

   a_sync_more: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ldw_pkg::ST_SYNC && !tc_r) |-> lad_oe_r && lad_out_r == ldw_pkg::SYNC_MORE)
      else $error("missing more-bytes sync");

   a_sync_done: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ldw_pkg::ST_SYNC && tc_r) |-> lad_oe_r && lad_out_r == ldw_pkg::SYNC_DONE ##1 done_r)
      else $error("missing final sync");

   a_data_nibs: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ldw_pkg::ST_SYNC) |=> s_data_out ##1 s_tar_release)
      else $error("data nibbles or turnaround wrong");

   a_req_frame: assert property (@(posedge sys_clk) disable iff (rst)
      ($fell(ldrq_n_r) && !$past(shifting_r)) |=> (ldrq_n_r == req_ch_r[2]) ##1 (ldrq_n_r == req_ch_r[1])
         ##1 (ldrq_n_r == req_ch_r[0]) ##1 ldrq_n_r ##1 ldrq_n_r ##1 req_pend_r)
      else $error("request frame malformed");

   a_chan_filter: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ldw_pkg::ST_CHAN && lframe_n && (lad_in[2:0] != req_ch_r || !req_pend_r))
         |=> state_r == ldw_pkg::ST_IDLE ##1 !lad_oe_r)
      else $error("answered a foreign channel");

   a_keep_pending: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(req_pend_r) |-> $past(state_r == ldw_pkg::ST_SYNC && tc_r))
      else $error("request progress lost");
endmodule
`default_nettype wire

// >>> verif/ldw_host.sv
// LPC host model: decodes serial DMA requests and runs DMA write byte cycles
`timescale 1ns/1ns
`default_nettype none
module ldw_host (
   // Clock
   input wire logic sys_clk,
   // Device side of the bus
   input wire logic [3:0] lad_out,
   input wire logic lad_oe,
   input wire logic ldrq_n,
   input wire logic xfer_done,
   // Host drive
   output logic lframe_n,
   output logic [3:0] host_lad,
   output logic host_oe
);
   // ==========================================================
   // Captured answer: {ldrq_n, lad_oe, lad_out} per clock
   logic [5:0] cap [10];
   logic done_seen;

   initial begin
      lframe_n = 1'b1;
      host_lad = 4'hF;
      host_oe = 1'b0;
      done_seen = 1'b0;
   end

   // ==========================================================
   // Byte cycle: host fields, then ten clocks of device answer
   task automatic byte_cycle(input logic [3:0] cyc, input logic [3:0] chn);
      @(posedge sys_clk);
      lframe_n <= 1'b0;
      host_lad <= 4'h0;
      host_oe <= 1'b1;
      @(posedge sys_clk);
      lframe_n <= 1'b1;
      host_lad <= cyc;
      @(posedge sys_clk);
      host_lad <= chn;
      @(posedge sys_clk);
      host_lad <= 4'h0;
      @(posedge sys_clk);
      host_lad <= 4'hF;
      @(posedge sys_clk);
      host_oe <= 1'b0;
      done_seen = 1'b0;
      for (int i = 0; i < 10; i++) begin
         @(negedge sys_clk);
         cap[i] = {ldrq_n, lad_oe, lad_out};
         if (i == 6) begin
            done_seen = xfer_done;
         end
      end
   endtask

   // ==========================================================
   // Request decode: {ch2, ch1, ch0, act, end}; all ones if none
   task automatic get_req(output logic [4:0] bits);
      int n;
      n = 0;
      bits = 5'h1F;
      @(negedge sys_clk);
      while (ldrq_n !== 1'b0 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      if (n < 300) begin
         for (int i = 4; i >= 0; i--) begin
            @(negedge sys_clk);
            bits[i] = ldrq_n;
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> verif/ldw_seq_tb_top.sv
// Self-checking testbench for the LPC DMA write byte sequencer
`timescale 1ns/1ns
`default_nettype none
module ldw_seq_tb_top;
   logic sys_clk;
   logic rst;
   logic lframe_n;
   logic [3:0] lad_in;
   logic [3:0] lad_out;
   logic [3:0] host_lad;
   logic [3:0] float_r = 4'h5;
   logic lad_oe;
   logic host_oe;
   logic ldrq_n;
   logic dma_en;
   logic [2:0] dma_chan;
   logic xfer_done;
   logic [7:0] wr_data;
   logic wr_valid;
   logic wr_ready;
   int miscompares;
   int samples_checked;

   // ==========================================================
   // Wire resolution; released wires wander every clock
   assign lad_in = lad_oe ? lad_out : (host_oe ? host_lad : float_r);

   always @(posedge sys_clk) begin
      float_r <= ~float_r;
   end

   ldw_seq ldw_seq_i (.sys_clk(sys_clk), .rst(rst), .lframe_n(lframe_n), .lad_in(lad_in),
      .lad_out(lad_out), .lad_oe(lad_oe), .ldrq_n(ldrq_n), .dma_en(dma_en), .dma_chan(dma_chan),
      .xfer_done(xfer_done), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready));

   ldw_host ldw_host_i (.sys_clk(sys_clk), .lad_out(lad_out), .lad_oe(lad_oe), .ldrq_n(ldrq_n),
      .xfer_done(xfer_done), .lframe_n(lframe_n), .host_lad(host_lad), .host_oe(host_oe));

   // ==========================================================
   // Shared helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   function automatic logic oe_any();
      logic r;
      r = 1'b0;
      for (int i = 0; i < 10; i++) r = r | ldw_host_i.cap[i][4];
      return r;
   endfunction

   // ==========================================================
   // Scenarios
   task automatic t_fill;
      int n;
      n = 0;
      while (wr_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      for (int i = 0; i < 17; i++) begin
         @(posedge sys_clk);
         wr_valid <= 1'b1;
         wr_data <= 8'h30 + 8'(i);
      end
      @(posedge sys_clk);
      wr_valid <= 1'b0;
      @(negedge sys_clk);
      check(8'(wr_ready), 8'h00);
   endtask

   task automatic t_request(input logic [2:0] chan);
      logic [4:0] bits;
      @(posedge sys_clk);
      dma_en <= 1'b1;
      dma_chan <= chan;
      ldw_host_i.get_req(bits);
      check(8'(bits), 8'({chan, 2'b11}));
   endtask

   task automatic t_byte(input logic [7:0] data, input logic tc, input logic [2:0] chan);
      ldw_host_i.byte_cycle(4'hA, {tc, chan});
      check(8'(ldw_host_i.cap[0][4]), 8'h00);
      for (int i = 1; i < 5; i++) check(8'(ldw_host_i.cap[i][4:0]), 8'h15);
      check(8'(ldw_host_i.cap[5][4:0]), tc ? 8'h10 : 8'h19);
      check(8'(ldw_host_i.cap[6][4:0]), {4'h1, data[3:0]});
      check(8'(ldw_host_i.cap[7][4:0]), {4'h1, data[7:4]});
      check(8'(ldw_host_i.cap[8][4:0]), 8'h1F);
      check(8'(ldw_host_i.cap[9][4]), 8'h00);
      check(8'(ldw_host_i.done_seen), 8'(tc));
   endtask

   task automatic t_foreign(input logic [2:0] chan);
      ldw_host_i.byte_cycle(4'hA, {1'b0, chan ^ 3'h1});
      check(8'(oe_any()), 8'h00);
      ldw_host_i.byte_cycle(4'h2, {1'b0, chan});
      check(8'(oe_any()), 8'h00);
   endtask

   task automatic t_quiet;
      logic hi;
      hi = 1'b1;
      for (int i = 6; i < 10; i++) hi = hi & ldw_host_i.cap[i][5];
      @(posedge sys_clk);
      dma_chan <= 3'h6;
      for (int i = 0; i < 4; i++) begin
         @(negedge sys_clk);
         hi = hi & ldrq_n;
      end
      check(8'(hi), 8'h01);
   endtask

   task automatic t_idle;
      logic [4:0] bits;
      ldw_host_i.get_req(bits);
      check(8'(bits), 8'h1F);
      check(8'(wr_ready), 8'h01);
   endtask

   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      #100000;
      miscompares++;
      report_and_stop;
   end

   initial begin
      miscompares = 0;
      samples_checked = 0;
      rst = 1'b1;
      dma_en = 1'b0;
      dma_chan = 3'h0;
      wr_data = 8'h00;
      wr_valid = 1'b0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      t_fill;
      t_request(3'h3);
      t_byte(8'h30, 1'b0, 3'h3);
      t_foreign(3'h3);
      t_byte(8'h31, 1'b1, 3'h3);
      t_quiet;
      t_request(3'h6);
      for (int i = 2; i < 16; i++) t_byte(8'h30 + 8'(i), i == 15, 3'h6);
      t_idle;
      report_and_stop;
   end
endmodule
`default_nettype wire
